// >>> stp_pkg.sv
`default_nettype none
package stp_pkg;

    // clock and timing
    localparam int CLK_PERIOD_NS  = 4;
    localparam int REF_STATIC_NS  = 40;   // reference quiet this long counts as stopped
    localparam int REF_STATIC_CYC = REF_STATIC_NS / CLK_PERIOD_NS;
    localparam int POR_MAX_MS     = 1;
    // strictly under the ceiling
    localparam int POR_MAX_CYC    = (POR_MAX_MS * 1000000) / CLK_PERIOD_NS - 1;
    localparam int POR_REF_EDGES  = 2048; // reset length in reference edges
    localparam int RESUME_EDGES   = 16;   // steady edges needed before waking up
    localparam int CNT_W          = 20;

    // bit clock and word layout
    localparam int BIT_CLK_MULT   = 10;   // bit clock cycles per reference cycle
    localparam int WORD_HALF_CYC  = BIT_CLK_MULT / 2;
    localparam int DATA_W         = 20;
    localparam int HALF_W         = 10;
    localparam int LANES          = 2;    // rising and falling edge bits
    localparam logic [DATA_W-1:0] RX_OE_FULL = 20'hfffff;
    localparam logic [DATA_W-1:0] RX_OE_HALF = 20'h003ff;

    // pattern polynomial x^7 + x^6 + 1
    localparam int PRBS_W     = 7;
    localparam int PRBS_TAP_A = 6;
    localparam int PRBS_TAP_B = 5;
    localparam logic [PRBS_W-1:0] PRBS_SEED = 7'h7f;

    // register map, byte addresses
    localparam logic [3:0] ADDR_CTRL   = 4'h0;
    localparam logic [3:0] ADDR_STATUS = 4'h4;
    localparam logic [3:0] ADDR_MASK   = 4'h8;
    localparam logic [3:0] ADDR_STATE  = 4'hc;
    localparam int CTRL_GEN_BIT    = 0;
    localparam int CTRL_TXFULL_BIT = 1;
    localparam logic [1:0] CTRL_RESET = 2'h2;
    localparam int EV_PDOWN    = 0;
    localparam int EV_POR_DONE = 1;
    localparam int EV_PAT_ERR  = 2;
    localparam int EV_W        = 3;

    typedef enum logic [1:0] {STP_OFF, STP_PDOWN, STP_POR, STP_RUN} stp_state_e;

endpackage
`default_nettype wire

// >>> stp_prbs_gen.sv
`timescale 1ns/1ps
`default_nettype none
module stp_prbs_gen
    import stp_pkg::*;
#(
    parameter int MAXB = 2
) (
    // clock and reset
    input  wire logic            clock_i,
    input  wire logic            rstn_i,
    // control
    input  wire logic            enable_i,
    input  wire logic [1:0]      nbits_i,
    // pattern bits, lane 0 first
    output logic      [MAXB-1:0] bits_o
);

    logic [PRBS_W-1:0] s_r;
    logic [PRBS_W-1:0] s_nxt;
    logic              fb;

    // advance one step per bit sent this cycle
    always_comb begin
        s_nxt  = s_r;
        bits_o = '0;
        fb     = 1'b0;
        for (int i = 0; i < MAXB; i++) begin
            if (i < int'(nbits_i)) begin
                fb        = s_nxt[PRBS_TAP_A] ^ s_nxt[PRBS_TAP_B];
                s_nxt     = {s_nxt[PRBS_W-2:0], fb};
                bits_o[i] = fb;
            end
        end
    end

    // restart from seed whenever disabled
    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            s_r <= PRBS_SEED;
        end else if (!enable_i) begin
            s_r <= PRBS_SEED;
        end else begin
            s_r <= s_nxt;
        end
    end

endmodule // stp_prbs_gen
`default_nettype wire

// >>> stp_prbs_chk.sv
`timescale 1ns/1ps
`default_nettype none
module stp_prbs_chk
    import stp_pkg::*;
#(
    parameter int MAXB = 2
) (
    // clock and reset
    input  wire logic            clock_i,
    input  wire logic            rstn_i,
    // control
    input  wire logic            enable_i,
    input  wire logic [1:0]      nbits_i,
    input  wire logic            force_err_i,
    // received bits, lane 0 first
    input  wire logic [MAXB-1:0] bits_i,
    // sticky error
    output logic                 err_o
);

    localparam int FW = $clog2(PRBS_W + 1);

    logic [PRBS_W-1:0] w_r;
    logic [PRBS_W-1:0] w_nxt;
    logic [FW-1:0]     f_r;
    logic [FW-1:0]     f_nxt;
    logic              miss;

    // self-synchronising: predict each bit from the last seven seen
    always_comb begin
        w_nxt = w_r;
        f_nxt = f_r;
        miss  = 1'b0;
        for (int i = 0; i < MAXB; i++) begin
            if (i < int'(nbits_i)) begin
                if (f_nxt == FW'(PRBS_W) &&
                    bits_i[i] != (w_nxt[PRBS_TAP_A] ^ w_nxt[PRBS_TAP_B])) begin
                    miss = 1'b1;
                end
                w_nxt = {w_nxt[PRBS_W-2:0], bits_i[i]};
                if (f_nxt != FW'(PRBS_W)) begin
                    f_nxt = f_nxt + FW'(1);
                end
            end
        end
    end

    // error holds until the checker is disabled and enabled again
    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            w_r   <= '0;
            f_r   <= '0;
            err_o <= 1'b0;
        end else if (!enable_i) begin
            w_r   <= '0;
            f_r   <= '0;
            err_o <= 1'b0;
        end else begin
            w_r <= w_nxt;
            f_r <= f_nxt;
            if (miss || force_err_i) begin
                err_o <= 1'b1;
            end
        end
    end

endmodule // stp_prbs_chk
`default_nettype wire

// >>> stp_serdes_ctrl.sv
// Function
// - lock-to-reference low stops tracking; byte clock copies the reference.
// - stopped reference: power-down, serial and receive outputs float.
// - reference toggling after power-down reruns power-on reset.
// - pattern checker, enabled by its pin, reports errors by pass low.
// - bit clock is ten times the reference, locked to it.
// - full rate sends on both bit clock edges.
// - global enable low disables all circuitry; the register port, status and interrupt logic stay active.
// - loopback feeds serialized transmit data into the receiver.
// - serial transmit outputs float during loopback.
// - generator plus loopback forms a self-test reported on pass.
// - generator and checker rates must match, else pass reports error; the mismatch is only flagged in loopback.
// - reset on power-up and when the reference first toggles.
// - during reset outputs float and byte clock stays low.
// - reset length scales with reference, capped at one millisecond.
// - receive rate select picks 10 or 20 bit words, independent of transmit.
`timescale 1ns/1ps
`default_nettype none
module stp_serdes_ctrl
    import stp_pkg::*;
#(
    parameter int POR_MAX   = POR_MAX_CYC,
    parameter int POR_EDGES = POR_REF_EDGES
) (
    // clock and reset
    input  wire logic              clock_i,
    input  wire logic              rstn_i,
    // control pins
    input  wire logic              chip_enable_i,
    input  wire logic              reference_clock_i,
    input  wire logic              lock_to_reference_n_i,
    input  wire logic              serial_loopback_enable_i,
    input  wire logic              pattern_check_enable_i,
    input  wire logic              rx_rate_select_i,
    // parallel transmit data and serial receive bits
    input  wire logic [DATA_W-1:0] tx_data_i,
    input  wire logic [LANES-1:0]  serial_rx_i,
    // register port
    input  wire logic [3:0]        reg_addr_i,
    input  wire logic [31:0]       reg_wdata_i,
    input  wire logic              reg_write_i,
    input  wire logic              reg_read_i,
    output logic      [31:0]       reg_rdata_o,
    // serial transmit pins
    output logic      [LANES-1:0]  serial_tx_pos_o,
    output logic      [LANES-1:0]  serial_tx_neg_o,
    output logic                   serial_tx_oe_o,
    // parallel receive side
    output logic      [DATA_W-1:0] rx_data_o,
    output logic      [DATA_W-1:0] rx_data_oe_o,
    output logic                   rx_byte_clk_o,
    // status
    output logic                   pattern_check_pass_o,
    output logic                   cdr_tracking_o,
    output logic                   irq_o
);

    stp_state_e          state_r;
    stp_state_e          state_nxt;
    logic                ref_q_r;
    logic                ref_edge;
    logic                ref_active;
    logic [CNT_W-1:0]    quiet_cnt_r;
    logic [CNT_W-1:0]    resume_cnt_r;
    logic                resume_ok;
    logic [CNT_W-1:0]    por_edge_r;
    logic [CNT_W-1:0]    por_cyc_r;
    logic                por_done;
    logic                run;
    logic [3:0]          tx_cnt_r;
    logic [3:0]          rx_cnt_r;
    logic [DATA_W-1:0]   tx_sr_r;
    logic [DATA_W-1:0]   tx_cur;
    logic [LANES-1:0]    tx_bits_r;
    logic [LANES-1:0]    gen_bits;
    logic [LANES-1:0]    rx_src;
    logic [DATA_W-1:0]   rx_sr_r;
    logic [DATA_W-1:0]   rx_sr_nxt;
    logic [1:0]          ctrl_r;
    logic [EV_W-1:0]     status_r;
    logic [EV_W-1:0]     mask_r;
    logic [EV_W-1:0]     ev;
    logic                gen_en;
    logic                tx_full;
    logic                chk_en;
    logic                chk_err;
    logic                chk_err_q_r;
    logic                rate_mismatch;
    logic [1:0]          tx_nbits;
    logic [1:0]          rx_nbits;

    assign run     = (state_r == STP_RUN);
    assign gen_en  = run && ctrl_r[CTRL_GEN_BIT];
    assign tx_full = ctrl_r[CTRL_TXFULL_BIT];
    assign chk_en  = run && pattern_check_enable_i;

    // reference activity, sampled as a pin
    assign ref_edge   = ref_q_r ^ reference_clock_i;
    assign ref_active = quiet_cnt_r < CNT_W'(REF_STATIC_CYC);
    assign resume_ok  = resume_cnt_r >= CNT_W'(RESUME_EDGES);

    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            ref_q_r     <= 1'b0;
            quiet_cnt_r <= '0;
        end else begin
            ref_q_r <= reference_clock_i;
            if (ref_edge) begin
                quiet_cnt_r <= '0;
            end else if (ref_active) begin
                quiet_cnt_r <= quiet_cnt_r + CNT_W'(1);
            end
        end
    end

    // steady edges before wake-up
    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            resume_cnt_r <= '0;
        end else if (!ref_active) begin
            resume_cnt_r <= '0;
        end else if (ref_edge && !resume_ok) begin
            resume_cnt_r <= resume_cnt_r + CNT_W'(1);
        end
    end

    // reset length tracks reference rate, capped
    assign por_done = (ref_edge && por_edge_r >= CNT_W'(POR_EDGES - 1)) ||
                      (por_cyc_r >= CNT_W'(POR_MAX));

    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            por_edge_r <= '0;
            por_cyc_r  <= '0;
        end else if (state_r != STP_POR) begin
            por_edge_r <= '0;
            por_cyc_r  <= '0;
        end else begin
            por_cyc_r <= por_cyc_r + CNT_W'(1);
            if (ref_edge) begin
                por_edge_r <= por_edge_r + CNT_W'(1);
            end
        end
    end

    // power state sequencing; reset release itself starts a power-on reset
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            STP_OFF: begin
                if (chip_enable_i) begin
                    state_nxt = STP_POR;
                end
            end
            STP_PDOWN: begin
                if (resume_ok) begin
                    state_nxt = STP_POR;
                end
            end
            STP_POR: begin
                if (!ref_active) begin
                    state_nxt = STP_PDOWN;
                end else if (por_done) begin
                    state_nxt = STP_RUN;
                end
            end
            STP_RUN: begin
                if (!ref_active) begin
                    state_nxt = STP_PDOWN;
                end
            end
            default: begin
                state_nxt = STP_POR;
            end
        endcase
        if (!chip_enable_i) begin
            state_nxt = STP_OFF;
        end
    end

    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            state_r <= STP_POR;
        end else begin
            state_r <= state_nxt;
        end
    end

    // word timing: one reference period is ten bit clock cycles
    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            tx_cnt_r <= '0;
            rx_cnt_r <= '0;
        end else if (!run) begin
            tx_cnt_r <= '0;
            rx_cnt_r <= '0;
        end else begin
            tx_cnt_r <= (tx_cnt_r == 4'(BIT_CLK_MULT - 1)) ? '0 : tx_cnt_r + 4'h1;
            rx_cnt_r <= (rx_cnt_r == 4'(BIT_CLK_MULT - 1)) ? '0 : rx_cnt_r + 4'h1;
        end
    end

    // pattern source shares the transmit lanes
    assign tx_nbits = tx_full ? 2'h2 : 2'h1;

    stp_prbs_gen #(
        .MAXB (LANES)
    ) u_gen (
        .clock_i  (clock_i),
        .rstn_i   (rstn_i),
        .enable_i (gen_en),
        .nbits_i  (tx_nbits),
        .bits_o   (gen_bits)
    );

    // serializer: two bits per cycle at full rate, one held bit at half rate
    assign tx_cur = (tx_cnt_r == 4'h0) ? tx_data_i : tx_sr_r;

    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            tx_sr_r   <= '0;
            tx_bits_r <= '0;
        end else if (!run) begin
            tx_sr_r   <= '0;
            tx_bits_r <= '0;
        end else if (tx_full) begin
            tx_sr_r   <= tx_cur >> LANES;
            tx_bits_r <= gen_en ? gen_bits : tx_cur[LANES-1:0];
        end else begin
            tx_sr_r   <= tx_cur >> 1;
            tx_bits_r <= gen_en ? {gen_bits[0], gen_bits[0]} : {tx_cur[0], tx_cur[0]};
        end
    end

    // serial pins float unless running and out of loopback
    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            serial_tx_pos_o <= '0;
            serial_tx_neg_o <= '0;
            serial_tx_oe_o  <= 1'b0;
        end else begin
            serial_tx_pos_o <= tx_bits_r;
            serial_tx_neg_o <= ~tx_bits_r;
            serial_tx_oe_o  <= run && !serial_loopback_enable_i;
        end
    end

    // loopback feeds the receiver from the transmit lanes
    assign rx_src = serial_loopback_enable_i ? tx_bits_r : serial_rx_i;

    // deserializer; lane 0 of the first cycle ends up in bit 0
    always_comb begin
        if (rx_rate_select_i) begin
            rx_sr_nxt = {rx_src[1], rx_src[0], rx_sr_r[DATA_W-1:LANES]};
        end else begin
            rx_sr_nxt = {rx_src[0], rx_sr_r[DATA_W-1:1]};
        end
    end

    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rx_sr_r      <= '0;
            rx_data_o    <= '0;
            rx_data_oe_o <= '0;
        end else if (!run) begin
            rx_sr_r      <= '0;
            rx_data_o    <= '0;
            rx_data_oe_o <= '0;
        end else begin
            rx_sr_r <= rx_sr_nxt;
            if (rx_cnt_r == 4'(BIT_CLK_MULT - 1)) begin
                if (rx_rate_select_i) begin
                    rx_data_o    <= rx_sr_nxt;
                    rx_data_oe_o <= RX_OE_FULL;
                end else begin
                    rx_data_o    <= {{HALF_W{1'b0}}, rx_sr_nxt[DATA_W-1:HALF_W]};
                    rx_data_oe_o <= RX_OE_HALF;
                end
            end
        end
    end

    // byte clock: reference copy when locked, else word phase
    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rx_byte_clk_o  <= 1'b0;
            cdr_tracking_o <= 1'b0;
        end else if (!run) begin
            rx_byte_clk_o  <= 1'b0;
            cdr_tracking_o <= 1'b0;
        end else if (!lock_to_reference_n_i) begin
            rx_byte_clk_o  <= reference_clock_i;
            cdr_tracking_o <= 1'b0;
        end else begin
            rx_byte_clk_o  <= rx_cnt_r < 4'(WORD_HALF_CYC);
            cdr_tracking_o <= 1'b1;
        end
    end

    // checker; in loopback a rate mismatch is an error in its own right
    assign rx_nbits      = rx_rate_select_i ? 2'h2 : 2'h1;
    assign rate_mismatch = serial_loopback_enable_i && (rx_rate_select_i != tx_full);

    stp_prbs_chk #(
        .MAXB (LANES)
    ) u_chk (
        .clock_i     (clock_i),
        .rstn_i      (rstn_i),
        .enable_i    (chk_en),
        .nbits_i     (rx_nbits),
        .force_err_i (rate_mismatch),
        .bits_i      (rx_src),
        .err_o       (chk_err)
    );

    // pass is high unless an enabled check has seen an error
    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            pattern_check_pass_o <= 1'b1;
            chk_err_q_r          <= 1'b0;
        end else begin
            pattern_check_pass_o <= !(chk_en && chk_err);
            chk_err_q_r          <= chk_err;
        end
    end

    // events for the status register
    assign ev[EV_PDOWN]    = (state_nxt == STP_PDOWN) && (state_r != STP_PDOWN);
    assign ev[EV_POR_DONE] = (state_r == STP_POR) && (state_nxt == STP_RUN);
    assign ev[EV_PAT_ERR]  = chk_err && !chk_err_q_r;

    // control and mask registers
    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            ctrl_r <= CTRL_RESET;
            mask_r <= '0;
        end else if (reg_write_i) begin
            if (reg_addr_i == ADDR_CTRL) begin
                ctrl_r <= reg_wdata_i[1:0];
            end
            if (reg_addr_i == ADDR_MASK) begin
                mask_r <= reg_wdata_i[EV_W-1:0];
            end
        end
    end

    // sticky status, write one to clear; a new event beats the clear
    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            status_r <= '0;
        end else if (reg_write_i && reg_addr_i == ADDR_STATUS) begin
            status_r <= (status_r & ~reg_wdata_i[EV_W-1:0]) | ev;
        end else begin
            status_r <= status_r | ev;
        end
    end

    // interrupt level follows unmasked status with one cycle of register delay
    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= |(status_r & mask_r);
        end
    end

    // read data stands only in the cycle after the read strobe
    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            reg_rdata_o <= '0;
        end else if (!reg_read_i) begin
            reg_rdata_o <= '0;
        end else begin
            case (reg_addr_i)
                ADDR_CTRL:   reg_rdata_o <= {30'h0, ctrl_r};
                ADDR_STATUS: reg_rdata_o <= {29'h0, status_r};
                ADDR_MASK:   reg_rdata_o <= {29'h0, mask_r};
                ADDR_STATE:  reg_rdata_o <= {28'h0, pattern_check_pass_o, cdr_tracking_o,
                                             state_r};
                default:     reg_rdata_o <= '0;
            endcase
        end
    end

endmodule // stp_serdes_ctrl
`default_nettype wire

// >>> stp_serdes_ctrl_chk.sv
`timescale 1ns/1ps
`default_nettype none
module stp_serdes_ctrl_chk
    import stp_pkg::*;
(
    // clock and reset
    input wire logic              clock_i,
    input wire logic              rstn_i,
    // control pins
    input wire logic              chip_enable_i,
    input wire logic              reference_clock_i,
    input wire logic              lock_to_reference_n_i,
    input wire logic              serial_loopback_enable_i,
    input wire logic              pattern_check_enable_i,
    input wire logic              rx_rate_select_i,
    // watched outputs
    input wire logic [LANES-1:0]  serial_tx_pos_o,
    input wire logic [LANES-1:0]  serial_tx_neg_o,
    input wire logic              serial_tx_oe_o,
    input wire logic [DATA_W-1:0] rx_data_oe_o,
    input wire logic              rx_byte_clk_o,
    input wire logic              pattern_check_pass_o,
    input wire logic              cdr_tracking_o
);
    logic       ref_q_r;
    logic [4:0] quiet_r;

    // cycles since reference moved, saturating
    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            ref_q_r <= 1'b0;
            quiet_r <= 5'h0;
        end else begin
            ref_q_r <= reference_clock_i;
            if (reference_clock_i != ref_q_r) quiet_r <= 5'h0;
            else if (quiet_r != 5'h1f) quiet_r <= quiet_r + 5'h1;
        end
    end

    default clocking @(posedge clock_i); endclocking
    default disable iff (!rstn_i);

    // state and pins both registered
    sequence s_off2; !chip_enable_i ##1 !chip_enable_i; endsequence
    sequence s_nochk; !pattern_check_enable_i [*3]; endsequence

    property p_lock; !lock_to_reference_n_i |=> !cdr_tracking_o; endproperty
    a_lock: assert property (p_lock) else $error("tracking while locked");
    property p_stop; quiet_r == 5'h10 |-> !serial_tx_oe_o && rx_data_oe_o == '0; endproperty
    a_stop: assert property (p_stop) else $error("pins driven, ref stopped");
    property p_loop; serial_loopback_enable_i |=> !serial_tx_oe_o; endproperty
    a_loop: assert property (p_loop) else $error("driven in loopback");
    property p_off;
        s_off2 |=> !serial_tx_oe_o && !rx_byte_clk_o && rx_data_oe_o == '0;
    endproperty
    a_off: assert property (p_off) else $error("active while off");
    property p_rate;
        $changed(rx_data_oe_o) && rx_data_oe_o != '0
            |-> rx_data_oe_o == ($past(rx_rate_select_i) ? RX_OE_FULL : RX_OE_HALF);
    endproperty
    a_rate: assert property (p_rate) else $error("receive width wrong");
    property p_cpl; serial_tx_oe_o |-> serial_tx_neg_o == ~serial_tx_pos_o; endproperty
    a_cpl: assert property (p_cpl) else $error("pair not complementary");
    property p_dis; s_nochk |-> pattern_check_pass_o; endproperty
    a_dis: assert property (p_dis) else $error("pass low with checker off");
    property p_stick;
        !pattern_check_pass_o && pattern_check_enable_i && chip_enable_i && quiet_r < 5'h8
            |=> !pattern_check_pass_o;
    endproperty
    a_stick: assert property (p_stick) else $error("error flag not sticky");
endmodule // stp_serdes_ctrl_chk

bind stp_serdes_ctrl stp_serdes_ctrl_chk chk_u (.*);
`default_nettype wire

// >>> stp_remote_model.sv
`timescale 1ns/1ps
`default_nettype none
module stp_remote_model
    import stp_pkg::*;
(
    // clock and reset
    input  wire logic             clock_i,
    input  wire logic             rstn_i,
    // scenario controls
    input  wire logic             ref_run_i,
    input  wire logic             stream_on_i,
    input  wire logic             half_i,
    input  wire logic             flip_i,
    // pins toward the device
    output logic                  reference_clock_o,
    output logic                  lock_to_reference_n_o,
    output logic [LANES-1:0]      serial_rx_o
);
    logic [PRBS_W-1:0] seq_r;
    logic [PRBS_W-1:0] s1;
    logic              b0;
    logic              b1;

    // host reference, still when stopped
    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) reference_clock_o <= 1'b0;
        else if (ref_run_i) reference_clock_o <= ~reference_clock_o;
    end

    // locked while no stream
    assign lock_to_reference_n_o = stream_on_i;

    // two bits per cycle, lane 0 first
    assign b0 = seq_r[PRBS_TAP_A] ^ seq_r[PRBS_TAP_B];
    assign s1 = {seq_r[PRBS_W-2:0], b0};
    assign b1 = s1[PRBS_TAP_A] ^ s1[PRBS_TAP_B];

    // remote sender; idle lines toggle
    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            seq_r <= PRBS_SEED;
            serial_rx_o <= '0;
        end else if (!stream_on_i) begin
            serial_rx_o <= ~serial_rx_o;
        end else if (half_i) begin
            serial_rx_o <= {~serial_rx_o[1], b0 ^ flip_i};
            seq_r <= s1;
        end else begin
            serial_rx_o <= {b1, b0 ^ flip_i};
            seq_r <= {s1[PRBS_W-2:0], b1};
        end
    end
endmodule // stp_remote_model
`default_nettype wire

// >>> stp_serdes_ctrl_bench.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin error_cnt++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, e); end end
module stp_serdes_ctrl_bench;
    import stp_pkg::*;
    logic              clock_i = 1'b0;
    logic              rstn_i = 1'b0;
    logic              chip_enable_i = 1'b1;
    logic              reference_clock_i, lock_to_reference_n_i;
    logic              serial_loopback_enable_i = 1'b0, pattern_check_enable_i = 1'b0;
    logic              rx_rate_select_i = 1'b1, ref_run = 1'b1, stream_on = 1'b1, flip = 1'b0;
    logic [DATA_W-1:0] tx_data_i = '0, rx_data_o, rx_data_oe_o, word;
    logic [LANES-1:0]  serial_rx_i, serial_tx_pos_o, serial_tx_neg_o;
    logic [3:0]        reg_addr_i = 4'h0;
    logic [31:0]       reg_wdata_i = '0, reg_rdata_o, exp_v;
    logic              reg_write_i = 1'b0, reg_read_i = 1'b0, rd_pend_r = 1'b0;
    logic              serial_tx_oe_o, rx_byte_clk_o, pattern_check_pass_o, cdr_tracking_o, irq_o;
    logic [15:0]       rnd = 16'h4c8c;
    logic [31:0]       exp_q[$];
    int                error_cnt = 0, n_tests = 0;

    stp_serdes_ctrl #(.POR_MAX(200), .POR_EDGES(8)) dut_u (.*);
    stp_remote_model far_u (.clock_i(clock_i), .rstn_i(rstn_i), .ref_run_i(ref_run),
        .stream_on_i(stream_on), .half_i(!rx_rate_select_i), .flip_i(flip),
        .reference_clock_o(reference_clock_i), .lock_to_reference_n_o(lock_to_reference_n_i),
        .serial_rx_o(serial_rx_i));

    initial forever #2 clock_i = ~clock_i;

    // read data checked mid-cycle, once settled
    always @(posedge clock_i) rd_pend_r <= reg_read_i;
    always @(negedge clock_i) begin
        if (rd_pend_r) begin
            exp_v = exp_q.pop_front();
            `CHK(reg_rdata_o, exp_v)
        end
    end

    function automatic logic [15:0] lfsr_next(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    task automatic cyc(input int n); repeat (n) @(posedge clock_i); endtask
    // idle edge after each strobe
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        reg_addr_i <= a; reg_wdata_i <= d; reg_write_i <= 1'b1;
        cyc(1); reg_write_i <= 1'b0; cyc(1);
    endtask
    task automatic rd(input logic [3:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        reg_addr_i <= a; reg_read_i <= 1'b1;
        cyc(1); reg_read_i <= 1'b0; cyc(1);
    endtask
    task automatic wait_run();
        for (int i = 0; i < 400 && serial_tx_oe_o !== 1'b1; i++) cyc(1);
        `CHK(serial_tx_oe_o, 1'b1)
    endtask
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    initial begin
        cyc(16); rstn_i <= 1'b1;
        rd(ADDR_STATE, 32'ha);
        `CHK({rx_data_oe_o, serial_tx_oe_o, rx_byte_clk_o}, 22'h0)
        rd(ADDR_CTRL, 32'h2);
        rd(4'h1, 32'h0);
        wait_run();
        rd(ADDR_STATUS, 32'h2);
        wr(ADDR_MASK, 32'h2); cyc(2); `CHK(irq_o, 1'b1)
        wr(ADDR_STATUS, 32'h2); cyc(2); `CHK(irq_o, 1'b0)
        // one flipped bit
        pattern_check_enable_i <= 1'b1; cyc(40);
        rd(ADDR_STATE, 32'hf);
        flip <= 1'b1; cyc(1); flip <= 1'b0; cyc(8);
        `CHK(pattern_check_pass_o, 1'b0)
        cyc(30); `CHK(pattern_check_pass_o, 1'b0)
        pattern_check_enable_i <= 1'b0; cyc(4);
        `CHK(pattern_check_pass_o, 1'b1)
        stream_on <= 1'b0; cyc(3);
        rd(ADDR_STATE, 32'hb);
        stream_on <= 1'b1; serial_loopback_enable_i <= 1'b1;
        // pairs survive loop offset
        repeat (3) begin
            rnd = lfsr_next(rnd);
            word = {10{rnd[1:0]}};
            tx_data_i <= word; cyc(30);
            `CHK(serial_tx_oe_o, 1'b0)
            `CHK(rx_data_o, word)
            `CHK(rx_data_oe_o, RX_OE_FULL)
        end
        rx_rate_select_i <= 1'b0; cyc(30);
        `CHK({rx_data_oe_o, rx_data_o[19:10]}, {RX_OE_HALF, 10'h0})
        rx_rate_select_i <= 1'b1; wr(ADDR_CTRL, 32'h3);
        pattern_check_enable_i <= 1'b1; cyc(60);
        rd(ADDR_STATE, 32'hf);
        rx_rate_select_i <= 1'b0; cyc(10);
        `CHK(pattern_check_pass_o, 1'b0)
        pattern_check_enable_i <= 1'b0; wr(ADDR_CTRL, 32'h1);
        pattern_check_enable_i <= 1'b1; cyc(60);
        `CHK(pattern_check_pass_o, 1'b1)
        pattern_check_enable_i <= 1'b0; serial_loopback_enable_i <= 1'b0;
        rx_rate_select_i <= 1'b1; wr(ADDR_CTRL, 32'h2);
        ref_run <= 1'b0; cyc(20);
        rd(ADDR_STATE, 32'h9);
        `CHK({rx_data_oe_o, serial_tx_oe_o}, 21'h0)
        ref_run <= 1'b1; wait_run();
        rd(ADDR_STATUS, 32'h7);
        chip_enable_i <= 1'b0; cyc(3);
        rd(ADDR_STATE, 32'h8);
        chip_enable_i <= 1'b1; cyc(1);
        rd(ADDR_STATE, 32'ha);
        wait_run();
        give_verdict();
    end

    // hang guard
    initial begin
        #20000;
        error_cnt++;
        give_verdict();
    end
endmodule // stp_serdes_ctrl_bench
`default_nettype wire
